// >>> ccx_pkg.sv
// Constants for the clear and complement execute block
// What this block does
// - Clear-file zeroes register and sets zero flag
// - Watchdog-clear resets watchdog counter in one cycle
// - Prescaler cleared only when assigned to watchdog
// - Watchdog-clear sets time-out and power-down flags
// - Complement-file with d zero writes working register
// - Complement-file with d one writes file back
package ccx_pkg;
    // Instruction word width
    localparam int INSN_W = 12;
    // Opcode patterns
    localparam logic [11:0] OP_WDOG_CLR = 12'h004;
    localparam logic [6:0] OP_CLR_FILE_HI = 7'h03;
    localparam logic [5:0] OP_COMP_FILE_HI = 6'h09;
    // Register map offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_INSN = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_WREG = 8'h0C;
    localparam logic [7:0] OFF_WDOG = 8'h10;
    localparam logic [7:0] OFF_FILE = 8'h80;
    // Status bit positions
    localparam int STAT_Z = 2;
    localparam int STAT_PWD_N = 3;
    localparam int STAT_TMO_N = 4;
    // Reset values
    localparam logic [7:0] STAT_RST = 8'h18;
    localparam logic [7:0] WDOG_RST = 8'h00;
    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> ccx_exec.sv
// Decode and execute of clear, watchdog-clear and complement instructions
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ccx_exec (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Whole module state
    typedef struct packed {
        logic [31:0][7:0] file; // Packed so the struct stays packed
        logic [7:0] wreg;
        logic [7:0] stat;
        logic [7:0] wdog;
        logic [7:0] presc;
        logic presc_wdog;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic aw_rdy; // Registered write address ready
        logic w_rdy; // Registered write data ready
        logic ar_rdy; // Registered read address ready
    } ccx_state_t;

    ccx_state_t st_reg;
    ccx_state_t st_next;
    logic [11:0] insn;
    logic [7:0] fsrc;
    logic [7:0] inv;

    // Tell whether a byte address falls on a word-aligned file slot
    function automatic logic is_file(input logic [7:0] a);
        return a[7] && (a[1:0] == 2'h0);
    endfunction

    // Write path, decode and execute
    always_comb begin
        st_next = st_reg;
        insn = 12'h000;
        fsrc = st_reg.file[0];
        inv = 8'h00;
        // Capture address and data in either order
        if (s_axi_awvalid && !st_reg.aw_got) begin
            st_next.aw_got = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_reg.w_got) begin
            st_next.w_got = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end
        // Both held and no response pending: perform write
        if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = ccx_pkg::RESP_OKAY;
            if (st_reg.aw_addr == ccx_pkg::OFF_INSN) begin
                // Instruction issue, executed in this single cycle
                insn = st_reg.w_data[11:0];
                fsrc = st_reg.file[insn[4:0]];
                inv = ~fsrc;
                if (insn == ccx_pkg::OP_WDOG_CLR) begin
                    st_next.wdog = 8'h00;
                    // Prescaler touched only when it serves the watchdog
                    if (st_reg.presc_wdog) begin
                        st_next.presc = 8'h00;
                    end
                    st_next.stat[ccx_pkg::STAT_TMO_N] = 1'b1;
                    st_next.stat[ccx_pkg::STAT_PWD_N] = 1'b1;
                end else if (insn[11:5] == ccx_pkg::OP_CLR_FILE_HI) begin
                    st_next.file[insn[4:0]] = 8'h00;
                    st_next.stat[ccx_pkg::STAT_Z] = 1'b1;
                end else if (insn[11:6] == ccx_pkg::OP_COMP_FILE_HI) begin
                    // Destination select
                    if (insn[5]) begin
                        st_next.file[insn[4:0]] = inv;
                    end else begin
                        st_next.wreg = inv;
                    end
                    st_next.stat[ccx_pkg::STAT_Z] = (inv == 8'h00);
                end
            end else if (st_reg.aw_addr == ccx_pkg::OFF_CTRL) begin
                // Prescaler assignment bit
                if (st_reg.w_strb[0]) begin
                    st_next.presc_wdog = st_reg.w_data[0];
                end
            end else if (st_reg.aw_addr == ccx_pkg::OFF_WREG) begin
                if (st_reg.w_strb[0]) begin
                    st_next.wreg = st_reg.w_data[7:0];
                end
            end else if (st_reg.aw_addr == ccx_pkg::OFF_WDOG) begin
                // Watchdog and prescaler preset for test
                if (st_reg.w_strb[0]) begin
                    st_next.wdog = st_reg.w_data[7:0];
                end
                if (st_reg.w_strb[1]) begin
                    st_next.presc = st_reg.w_data[15:8];
                end
            end else if (st_reg.aw_addr == ccx_pkg::OFF_STAT) begin
                if (st_reg.w_strb[0]) begin
                    st_next.stat = st_reg.w_data[7:0];
                end
            end else if (is_file(st_reg.aw_addr)) begin
                if (st_reg.w_strb[0]) begin
                    st_next.file[st_reg.aw_addr[6:2]] = st_reg.w_data[7:0];
                end
            end else begin
                // Unmapped address
                st_next.bresp = ccx_pkg::RESP_SLVERR;
            end
        end
        // Write response handshake
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        // Read address accepted when no data pending
        if (s_axi_arvalid && !st_reg.rvalid) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = ccx_pkg::RESP_OKAY;
            st_next.rdata = 32'h0000_0000;
            if (s_axi_araddr == ccx_pkg::OFF_CTRL) begin
                st_next.rdata[0] = st_reg.presc_wdog;
            end else if (s_axi_araddr == ccx_pkg::OFF_INSN) begin
                st_next.rdata = 32'h0000_0000;
            end else if (s_axi_araddr == ccx_pkg::OFF_STAT) begin
                st_next.rdata[7:0] = st_reg.stat;
            end else if (s_axi_araddr == ccx_pkg::OFF_WREG) begin
                st_next.rdata[7:0] = st_reg.wreg;
            end else if (s_axi_araddr == ccx_pkg::OFF_WDOG) begin
                st_next.rdata[15:0] = {st_reg.presc, st_reg.wdog};
            end else if (is_file(s_axi_araddr)) begin
                st_next.rdata[7:0] = st_reg.file[s_axi_araddr[6:2]];
            end else begin
                st_next.rresp = ccx_pkg::RESP_SLVERR;
            end
        end else if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        // Readies kept in flops so outputs leave a register directly
        st_next.aw_rdy = !st_next.aw_got;
        st_next.w_rdy = !st_next.w_got;
        st_next.ar_rdy = !st_next.rvalid;
    end

    // State register with synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
            st_reg.stat <= ccx_pkg::STAT_RST;
            st_reg.wdog <= ccx_pkg::WDOG_RST;
            // All channels ready out of reset
            st_reg.aw_rdy <= 1'b1;
            st_reg.w_rdy <= 1'b1;
            st_reg.ar_rdy <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Bus outputs straight from state
    always_comb begin
        s_axi_awready = st_reg.aw_rdy;
        s_axi_wready = st_reg.w_rdy;
        s_axi_bvalid = st_reg.bvalid;
        s_axi_bresp = st_reg.bresp;
        s_axi_arready = st_reg.ar_rdy;
        s_axi_rvalid = st_reg.rvalid;
        s_axi_rdata = st_reg.rdata;
        s_axi_rresp = st_reg.rresp;
    end

    // Instruction issue strobe seen by assertions
    logic issue;
    assign issue = aresetn && st_reg.aw_got && st_reg.w_got && !st_reg.bvalid
        && (st_reg.aw_addr == ccx_pkg::OFF_INSN);
    logic [11:0] iw;
    assign iw = st_reg.w_data[11:0];

    sequence s_issue_wdog;
        issue && iw == ccx_pkg::OP_WDOG_CLR;
    endsequence

    a_clear_file_op_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        issue && iw[11:5] == ccx_pkg::OP_CLR_FILE_HI
        |=> st_reg.file[$past(iw[4:0])] == 8'h00
        && st_reg.stat[ccx_pkg::STAT_Z]) else $error("clear-file failed");
    a_wdog_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        s_issue_wdog |=> st_reg.wdog == 8'h00) else $error("watchdog not cleared");
    a_presc_kept: assert property (@(posedge aclk) disable iff (!aresetn)
        s_issue_wdog
        |=> st_reg.presc == ($past(st_reg.presc_wdog) ? 8'h00 : $past(st_reg.presc)))
        else $error("prescaler handling wrong");
    a_flags_set: assert property (@(posedge aclk) disable iff (!aresetn)
        s_issue_wdog
        |=> st_reg.stat[ccx_pkg::STAT_TMO_N] && st_reg.stat[ccx_pkg::STAT_PWD_N])
        else $error("status flags not set");
    a_complement_file_op_w: assert property (@(posedge aclk) disable iff (!aresetn)
        issue && iw[11:6] == ccx_pkg::OP_COMP_FILE_HI && !iw[5]
        |=> st_reg.wreg == ~$past(st_reg.file[iw[4:0]])) else $error("complement to W wrong");
    a_complement_file_op_f: assert property (@(posedge aclk) disable iff (!aresetn)
        issue && iw[11:6] == ccx_pkg::OP_COMP_FILE_HI && iw[5]
        |=> st_reg.file[$past(iw[4:0])] == ~$past(st_reg.file[iw[4:0]]))
        else $error("complement to file wrong");
    a_complement_file_op_z: assert property (@(posedge aclk) disable iff (!aresetn)
        issue && iw[11:6] == ccx_pkg::OP_COMP_FILE_HI
        |=> st_reg.stat[ccx_pkg::STAT_Z] == ($past(st_reg.file[iw[4:0]]) == 8'hFF)
        && st_reg.stat[ccx_pkg::STAT_TMO_N] == $past(st_reg.stat[ccx_pkg::STAT_TMO_N]))
        else $error("zero flag wrong after complement");
    a_resp_after: assert property (@(posedge aclk) disable iff (!aresetn)
        issue |=> s_axi_bvalid) else $error("no write response after issue");
endmodule
`default_nettype wire

// >>> ccx_exec_tb_top.sv
// Self-checking bench for the clear and complement execute block
`timescale 1ns/1ps
`default_nettype none
module ccx_exec_tb_top;
    logic aclk; // Core clock
    logic aresetn; // Sync reset, low active
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    int failures; // Mismatch count
    int samples_checked; // Comparison count
    int cycles = 0; // Timeout counter

    ccx_exec u_ccx_exec (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));

    // 40 ns clock
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // Compare a data word
    task automatic chk_data(input logic [7:0] a, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR rdata addr %h expected %h seen %h", a, e, g);
        end
    endtask

    // Compare a response code
    task automatic chk_resp(input logic [7:0] a, input logic [1:0] e, input logic [1:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR resp addr %h expected %h seen %h", a, e, g);
        end
    endtask

    // One write; address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        // Wait for the response
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        chk_resp(a, er, s_axi_bresp);
        s_axi_bready <= 1'b0;
        // Let an edge pass before the next call drives the bus again
        @(posedge aclk);
    endtask

    // One read; data checked only when an OKAY answer is expected
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        chk_resp(a, er, s_axi_rresp);
        if (er === ccx_pkg::RESP_OKAY) begin
            chk_data(a, e, s_axi_rdata);
        end
        s_axi_rready <= 1'b0;
        // Let an edge pass before the next call drives the bus again
        @(posedge aclk);
    endtask

    // Counts, verdict, stop
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            end_sim();
        end
    end

    // Main sequence
    initial begin
        failures = 0;
        samples_checked = 0;
        aresetn <= 1'b0;
        s_axi_awaddr <= 8'h00; s_axi_awvalid <= 1'b0; s_axi_wdata <= 32'h0;
        s_axi_wstrb <= 4'hF; s_axi_wvalid <= 1'b0; s_axi_bready <= 1'b0;
        s_axi_araddr <= 8'h00; s_axi_arvalid <= 1'b0; s_axi_rready <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset state
        rd(8'h08, 32'h18, 2'h0);
        rd(8'h0C, 32'h00, 2'h0);
        $display("Test reset done");
        // Clear file, low and top register
        wr(8'h94, 32'h5A, 2'h0);
        wr(8'hFC, 32'hFF, 2'h0);
        wr(8'h08, 32'h00, 2'h0);
        wr(8'h04, 32'h065, 2'h0);
        rd(8'h94, 32'h00, 2'h0);
        rd(8'h08, 32'h04, 2'h0);
        wr(8'h04, 32'h07F, 2'h0);
        rd(8'hFC, 32'h00, 2'h0);
        $display("Test clear file done");
        // Watchdog clear, prescaler on timer then on watchdog
        wr(8'h00, 32'h0, 2'h0);
        wr(8'h10, 32'h3377, 2'h0);
        wr(8'h08, 32'h04, 2'h0);
        wr(8'h04, 32'h004, 2'h0);
        rd(8'h10, 32'h3300, 2'h0);
        rd(8'h08, 32'h1C, 2'h0);
        wr(8'h00, 32'h1, 2'h0);
        wr(8'h10, 32'h3377, 2'h0);
        wr(8'h08, 32'h00, 2'h0);
        wr(8'h04, 32'h004, 2'h0);
        rd(8'h10, 32'h0000, 2'h0);
        rd(8'h08, 32'h18, 2'h0);
        $display("Test watchdog clear done");
        // Complement to working register, nonzero result
        wr(8'h9C, 32'h5A, 2'h0);
        wr(8'h08, 32'h1C, 2'h0);
        wr(8'h04, 32'h247, 2'h0);
        rd(8'h0C, 32'hA5, 2'h0);
        rd(8'h9C, 32'h5A, 2'h0);
        rd(8'h08, 32'h18, 2'h0);
        // Complement back to file, zero result
        wr(8'hA0, 32'hFF, 2'h0);
        wr(8'h08, 32'h08, 2'h0);
        wr(8'h04, 32'h268, 2'h0);
        rd(8'hA0, 32'h00, 2'h0);
        rd(8'h0C, 32'hA5, 2'h0);
        rd(8'h08, 32'h0C, 2'h0);
        $display("Test complement done");
        // Unmapped place
        wr(8'h40, 32'h1, ccx_pkg::RESP_SLVERR);
        rd(8'h40, 32'h0, ccx_pkg::RESP_SLVERR);
        $display("Test unmapped done");
        end_sim();
    end
endmodule
`default_nettype wire
